// *** logic/uti_datapath.sv ***
// serial port transmit/receive datapath with axi4-lite register slave
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module uti_datapath (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_NRST,
  // axi4-lite write address and data
  input wire logic [31:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  // axi4-lite write response
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // axi4-lite read
  input wire logic [31:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // serial pins
  input wire logic I_RX,
  output logic O_TX,
  // interrupt requests
  output logic O_TX_IRQ,
  output logic O_RX_IRQ
);
  import uti_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_hold;
    logic w_hold;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic tx_ninth;
    logic stop2;
    logic nine;
    logic brk_req;
    logic rx_en;
    logic tx_en;
    logic txe_ie;
    logic rx_ie;
    logic [7:0] div;
    logic seen;
    uti_tx_e tst;
    logic [3:0] tsub;
    logic [3:0] tcnt;
    logic [8:0] tsh;
    logic tbrk;
    logic tline;
    logic [8:0] tbuf;
    logic tfull;
    logic tempty;
    logic tx_idle_flag;
    logic [8:0] bcnt;
    uti_rx_e rst;
    logic [3:0] rsub;
    logic [3:0] rcnt;
    logic [8:0] rsh;
    logic rprev;
    logic rx_idle_flag;
    logic [1:0][8:0] mem;
    logic rptr;
    logic [1:0] rcount;
    logic framing_error_flag;
    logic overrun_flag;
    logic tx_irq;
    logic rx_irq;
  } uti_state_s;

  uti_state_s cur, next_s;
  logic f_tick;
  logic f_rx;
  logic f_maj;

  function automatic logic [3:0] last_bit(input logic nine);
    last_bit = nine ? LAST_BIT9 : LAST_BIT8;
  endfunction : last_bit

  // divider, synchroniser and voter for the receive pin
  uti_rx_front u_front (
    .i_clk(I_MCLK),
    .i_nrst(I_NRST),
    .i_div(cur.div),
    .i_rx(I_RX),
    .o_tick(f_tick),
    .o_rx(f_rx),
    .o_maj(f_maj)
  );

  always_comb begin
    logic wr_go;
    logic data_wr;
    logic data_rd;
    logic stat_rd;
    logic brk_go;
    logic [8:0] word;
    logic [8:0] head;
    logic pop;
    logic push;
    logic push_framing_error_flag;
    logic [1:0] cnt_after;
    wr_go = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    stat_rd = 1'b0;
    word = '0;
    push = 1'b0;
    push_framing_error_flag = 1'b0;
    brk_go = 1'b0;
    pop = 1'b0;
    cnt_after = 2'h0;
    next_s = cur;
    next_s.rx_irq = 1'b0;
    head = cur.mem[cur.rptr];

    // write channels are taken independently, executed once both are held
    if (I_AWVALID && cur.awready) begin
      next_s.aw_hold = 1'b1;
      next_s.awaddr = I_AWADDR;
    end
    if (I_WVALID && cur.wready) begin
      next_s.w_hold = 1'b1;
      next_s.wdata = I_WDATA;
      next_s.wstrb = I_WSTRB;
    end
    if (cur.bvalid && I_BREADY) begin
      next_s.bvalid = 1'b0;
    end
    wr_go = cur.aw_hold && cur.w_hold && !cur.bvalid;
    if (wr_go) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (cur.awaddr)
        OFF_STATUS: begin
          next_s.bresp = RESP_OKAY;
        end
        OFF_DATA: begin
          data_wr = cur.wstrb[0];
        end
        OFF_CTRL1: begin
          if (cur.wstrb[0]) begin
            next_s.tx_ninth = cur.wdata[C1_TX9];
            next_s.stop2 = cur.wdata[C1_STOP2];
            next_s.nine = cur.wdata[C1_NINE];
            next_s.brk_req = cur.wdata[C1_BRK];
            next_s.rx_en = cur.wdata[C1_RECEIVER_ENABLE];
            next_s.tx_en = cur.wdata[C1_TRANSMITTER_ENABLE];
          end
        end
        OFF_CTRL2: begin
          if (cur.wstrb[0]) begin
            next_s.txe_ie = cur.wdata[C2_TX_EMPTY_IRQ_ENABLE];
            next_s.rx_ie = cur.wdata[C2_RIE];
          end
          if (cur.wstrb[1]) begin
            next_s.div = cur.wdata[C2_DIV_LSB +: 8];
          end
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end
    next_s.awready = !next_s.aw_hold && !next_s.bvalid;
    next_s.wready = !next_s.w_hold && !next_s.bvalid;

    // read channel: data is registered on the address handshake
    if (cur.rvalid && I_RREADY) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (I_ARVALID && cur.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      case (I_ARADDR)
        OFF_STATUS: begin
          stat_rd = 1'b1;
          next_s.rdata[ST_FRAMING_ERROR_FLAG] = cur.framing_error_flag;
          next_s.rdata[ST_OVERRUN_FLAG] = cur.overrun_flag;
          next_s.rdata[ST_RX_IDLE_FLAG] = cur.rx_idle_flag;
          next_s.rdata[ST_RAVAIL] = cur.rcount != 2'h0;
          next_s.rdata[ST_TX_IDLE_FLAG] = cur.tx_idle_flag;
          next_s.rdata[ST_TEMPTY] = cur.tempty;
        end
        OFF_DATA: begin
          data_rd = 1'b1;
          next_s.rdata[7:0] = head[7:0];
        end
        OFF_CTRL1: begin
          next_s.rdata[C1_TX9] = cur.tx_ninth;
          next_s.rdata[C1_RX9] = head[8];
          next_s.rdata[C1_STOP2] = cur.stop2;
          next_s.rdata[C1_NINE] = cur.nine;
          next_s.rdata[C1_BRK] = cur.brk_req;
          next_s.rdata[C1_RECEIVER_ENABLE] = cur.rx_en;
          next_s.rdata[C1_TRANSMITTER_ENABLE] = cur.tx_en;
        end
        OFF_CTRL2: begin
          next_s.rdata[C2_TX_EMPTY_IRQ_ENABLE] = cur.txe_ie;
          next_s.rdata[C2_RIE] = cur.rx_ie;
          next_s.rdata[C2_DIV_LSB +: 8] = cur.div;
        end
        default: begin
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // status read arms the clear sequence; a data read, or a data write with strobe bit 0 set, consumes it
    if (data_wr || data_rd) begin
      next_s.seen = 1'b0;
    end
    if (stat_rd) begin
      next_s.seen = 1'b1;
    end

    // break arming: request must stay high for more than divisor+1 cycles
    if (!cur.brk_req || !cur.tx_idle_flag || cur.tst != TX_IDLE) begin
      next_s.bcnt = 9'h000;
    end else if (cur.bcnt <= {1'b0, cur.div}) begin
      next_s.bcnt = cur.bcnt + 9'h001;
    end
    brk_go = cur.bcnt > {1'b0, cur.div};

    // transmitter; buffered data survives a disable so load-then-enable works
    if (!cur.tx_en) begin
      if (cur.tst != TX_IDLE) begin
        next_s.tx_idle_flag = 1'b1;
      end
      next_s.tst = TX_IDLE;
      next_s.tsub = 4'h0;
    end else begin
      unique case (cur.tst)
        TX_IDLE: begin
          next_s.tsub = 4'h0;
          if (cur.tfull) begin
            next_s.tsh = cur.tbuf;
            next_s.tfull = 1'b0;
            next_s.tempty = 1'b1;
            next_s.tbrk = 1'b0;
            next_s.tst = TX_START;
          end else if (brk_go) begin
            next_s.tbrk = 1'b1;
            next_s.tx_idle_flag = 1'b0;
            next_s.tst = TX_START;
          end
        end
        TX_START, TX_DATA, TX_BRK, TX_STOP: begin
          if (f_tick) begin
            next_s.tsub = cur.tsub + 4'h1;
            if (cur.tsub == SUB_LAST) begin
              next_s.tcnt = cur.tcnt + 4'h1;
              unique case (cur.tst)
                TX_START: begin
                  next_s.tcnt = 4'h0;
                  next_s.tst = cur.tbrk ? TX_BRK : TX_DATA;
                end
                TX_DATA: begin
                  next_s.tsh = {1'b0, cur.tsh[8:1]};
                  if (cur.tcnt == last_bit(cur.nine)) begin
                    next_s.tcnt = 4'h0;
                    next_s.tst = TX_STOP;
                  end
                end
                TX_BRK: begin
                  if (cur.tcnt == BRK_LAST) begin
                    next_s.tcnt = 4'h0;
                    if (!cur.brk_req) begin
                      next_s.tst = TX_STOP;
                    end
                  end
                end
                default: begin
                  if (cur.tcnt == {3'h0, cur.stop2}) begin
                    next_s.tst = TX_IDLE;
                    next_s.tx_idle_flag = 1'b1;
                  end
                end
              endcase
            end
          end
        end
      endcase
    end

    // data write; refused unless status was read and the buffer is empty
    if (data_wr && cur.seen && cur.tempty) begin
      word = {cur.nine & cur.tx_ninth, cur.wdata[7:0]};
      next_s.tx_idle_flag = 1'b0;
      if (cur.tx_en && cur.tst == TX_IDLE && !cur.tfull && !brk_go) begin
        next_s.tsh = word;
        next_s.tbrk = 1'b0;
        next_s.tsub = 4'h0;
        next_s.tst = TX_START;
      end else begin
        next_s.tbuf = word;
        next_s.tfull = 1'b1;
        next_s.tempty = 1'b0;
      end
    end

    unique case (next_s.tst)
      TX_START: next_s.tline = 1'b0;
      TX_DATA: next_s.tline = next_s.tsh[0];
      TX_BRK: next_s.tline = 1'b0;
      TX_STOP: next_s.tline = 1'b1;
      TX_IDLE: next_s.tline = 1'b1;
    endcase
    // break leaves the empty flag alone, so it never requests here
    next_s.tx_irq = next_s.tempty && cur.txe_ie;

    // receiver
    pop = data_rd && cur.seen && cur.rcount != 2'h0;
    cnt_after = cur.rcount - {1'b0, pop};
    if (pop) begin
      next_s.rptr = ~cur.rptr;
      next_s.overrun_flag = 1'b0;
      next_s.framing_error_flag = 1'b0;
    end
    next_s.rprev = f_rx;
    if (!cur.rx_en) begin
      next_s.rst = RX_IDLE;
      next_s.rx_idle_flag = 1'b1;
    end else begin
      unique case (cur.rst)
        RX_IDLE: begin
          if (cur.rprev && !f_rx) begin
            next_s.rst = RX_START;
            next_s.rsub = 4'h0;
            next_s.rx_idle_flag = 1'b0;
          end
        end
        RX_WAIT: begin
          if (f_tick && f_maj) begin
            next_s.rst = RX_IDLE;
          end
        end
        RX_START, RX_DATA, RX_STOP: begin
          if (f_tick) begin
            next_s.rsub = cur.rsub + 4'h1;
            // decisions fall at mid-bit; the next lands sixteen ticks on
            if (cur.rsub == SUB_MID) begin
              unique case (cur.rst)
                RX_START: begin
                  if (f_maj) begin
                    next_s.rst = RX_IDLE;
                    next_s.rx_idle_flag = 1'b1;
                  end else begin
                    next_s.rcnt = 4'h0;
                    next_s.rst = RX_DATA;
                  end
                end
                RX_DATA: begin
                  next_s.rsh = {f_maj, cur.rsh[8:1]};
                  next_s.rcnt = cur.rcnt + 4'h1;
                  if (cur.rcnt == last_bit(cur.nine)) begin
                    next_s.rst = RX_STOP;
                  end
                end
                default: begin
                  push = 1'b1;
                  push_framing_error_flag = !f_maj;
                  next_s.rx_idle_flag = 1'b1;
                  next_s.rst = f_maj ? RX_IDLE : RX_WAIT;
                end
              endcase
            end
          end
        end
      endcase
    end

    if (push) begin
      next_s.rx_irq = cur.rx_ie;
      if (push_framing_error_flag) begin
        next_s.framing_error_flag = 1'b1;
      end
      if (cnt_after == FIFO_DEPTH) begin
        next_s.overrun_flag = 1'b1;
      end else begin
        next_s.mem[cur.rptr ^ cur.rcount[0]] = cur.nine ? cur.rsh : {1'b0, cur.rsh[8:1]};
        next_s.rcount = cnt_after + 2'h1;
      end
    end else begin
      next_s.rcount = cnt_after;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cur <= '0;
      cur.arready <= 1'b1;
      cur.awready <= 1'b1;
      cur.wready <= 1'b1;
      cur.div <= DIV_RST;
      cur.tst <= TX_IDLE;
      cur.rst <= RX_IDLE;
      cur.tline <= 1'b1;
      cur.tempty <= 1'b1;
      cur.tx_idle_flag <= 1'b1;
      cur.rx_idle_flag <= 1'b1;
      cur.rprev <= 1'b1;
    end else begin
      cur <= next_s;
    end
  end

  assign O_AWREADY = cur.awready;
  assign O_WREADY = cur.wready;
  assign O_BRESP = cur.bresp;
  assign O_BVALID = cur.bvalid;
  assign O_ARREADY = cur.arready;
  assign O_RDATA = cur.rdata;
  assign O_RRESP = cur.rresp;
  assign O_RVALID = cur.rvalid;
  assign O_TX = cur.tline;
  assign O_TX_IRQ = cur.tx_irq;
  assign O_RX_IRQ = cur.rx_irq;
endmodule : uti_datapath

// *** inc/uti_pkg.sv ***
// constants, types and register map of the serial transmit/receive datapath
package uti_pkg;
  localparam logic [31:0] OFF_STATUS = 32'h0000_0000;
  localparam logic [31:0] OFF_DATA = 32'h0000_0004;
  localparam logic [31:0] OFF_CTRL1 = 32'h0000_0008;
  localparam logic [31:0] OFF_CTRL2 = 32'h0000_000c;
  // status bits
  localparam int ST_FRAMING_ERROR_FLAG = 2;
  localparam int ST_OVERRUN_FLAG = 3;
  localparam int ST_RX_IDLE_FLAG = 4;
  localparam int ST_RAVAIL = 5;
  localparam int ST_TX_IDLE_FLAG = 6;
  localparam int ST_TEMPTY = 7;
  // control one bits
  localparam int C1_TX9 = 0;
  localparam int C1_RX9 = 1;
  localparam int C1_STOP2 = 2;
  localparam int C1_NINE = 3;
  localparam int C1_BRK = 4;
  localparam int C1_RECEIVER_ENABLE = 5;
  localparam int C1_TRANSMITTER_ENABLE = 6;
  // control two bits
  localparam int C2_TX_EMPTY_IRQ_ENABLE = 0;
  localparam int C2_RIE = 1;
  localparam int C2_DIV_LSB = 8;
  localparam logic [7:0] DIV_RST = 8'h0c;
  // bit timing in 16x ticks
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_MID = 4'h8;
  localparam logic [3:0] BRK_LAST = 4'hc;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_BRK = 5'h08, TX_STOP = 5'h10
  } uti_tx_e;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_STOP = 5'h08, RX_WAIT = 5'h10
  } uti_rx_e;
endpackage : uti_pkg

// *** logic/uti_rx_front.sv ***
// baud tick divider, receive pin synchroniser and majority voter
`timescale 1ns/1ps
module uti_rx_front (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // divisor and pin
  input wire logic [7:0] i_div,
  input wire logic i_rx,
  // results
  output logic o_tick,
  output logic o_rx,
  output logic o_maj
);
  import uti_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
    logic s1;
    logic s2;
    logic [2:0] smp;
    logic maj;
  } uti_front_s;
  uti_front_s cur, nxt;

  function automatic logic vote(input logic [2:0] v);
    vote = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : vote

  always_comb begin
    nxt = cur;
    nxt.s1 = i_rx;
    nxt.s2 = cur.s1;
    nxt.tick = 1'b0;
    nxt.cnt = cur.cnt + 8'h01;
    // tick rate is clock / (divisor+1), i.e. sixteen per bit
    if (cur.cnt >= i_div) begin
      nxt.cnt = 8'h00;
      nxt.tick = 1'b1;
    end
    if (cur.tick) begin
      nxt.smp = {cur.smp[1:0], cur.s2};
      nxt.maj = vote({cur.smp[1:0], cur.s2});
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cur <= '0;
      cur.s1 <= 1'b1;
      cur.s2 <= 1'b1;
      cur.smp <= 3'h7;
      cur.maj <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  assign o_tick = cur.tick;
  assign o_rx = cur.s2;
  assign o_maj = cur.maj;
endmodule : uti_rx_front

// *** bench/uti_datapath_properties.sv ***
// port-level checks on the serial datapath, bound into the design
`timescale 1ns/1ps
module uti_datapath_properties (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_NRST,
  // bus handshakes
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  // serial side
  input wire logic O_TX,
  input wire logic O_RX_IRQ
);
  logic [15:0] low_run;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);
  // saturating count of low cycles, so a stuck line cannot wrap to a short run
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) low_run <= 16'h0000;
    else if (O_TX) low_run <= 16'h0000;
    else if (low_run != 16'hffff) low_run <= low_run + 16'h0001;
  end
  property p_tx_bit_len; $rose(O_TX) |-> low_run >= 16'h0010; endproperty
  a_tx_bit_len: assert property (p_tx_bit_len) else $error("line low for less than one bit");
  property p_tx_rest; $rose(I_NRST) |-> O_TX [*2]; endproperty
  a_tx_rest: assert property (p_tx_rest) else $error("line not resting high");
  property p_rx_pulse; O_RX_IRQ |=> !O_RX_IRQ; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive request longer than a cycle");
  // the pair is held one cycle before the response is launched, so it is seen two edges on
  property p_wr_answer; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_wr_block; O_BVALID |-> !O_AWREADY && !O_WREADY; endproperty
  a_wr_block: assert property (p_wr_block) else $error("write taken during response");
  property p_wr_done; O_BVALID && I_BREADY |=> !O_BVALID && O_AWREADY && O_WREADY; endproperty
  a_wr_done: assert property (p_wr_done) else $error("write response not retired");
  property p_rd_answer; I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  property p_rd_done; O_RVALID && I_RREADY |=> !O_RVALID && O_ARREADY; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read data not retired");
  c_rx_word: cover property (O_RX_IRQ);
  c_slverr: cover property (O_BVALID && O_BRESP == 2'h2);
  c_frame: cover property ($rose(O_TX));
endmodule : uti_datapath_properties

bind uti_datapath uti_datapath_properties u_props (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .O_BRESP(O_BRESP), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
  .O_TX(O_TX), .O_RX_IRQ(O_RX_IRQ));

// *** bench/uti_remote.sv ***
// far-side serial device: drives the receive pin and decodes the transmit pin
`timescale 1ns/1ps
module uti_remote #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input wire logic i_clk,
  // pins seen from the far side
  input wire logic i_tx,
  output logic o_rx
);
  initial o_rx = 1'h1;
  task automatic send(input logic [8:0] w, input int n, input logic stop_lvl);
    o_rx <= 1'h0;
    repeat (BIT_CLKS) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_rx <= w[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    // a low stop is held five bits: fourteen low bits in all make a break
    o_rx <= stop_lvl;
    repeat (stop_lvl ? BIT_CLKS : 5 * BIT_CLKS) @(posedge i_clk);
    // one idle clock, so a following call never drives the pin twice in one step
    o_rx <= 1'h1;
    @(posedge i_clk);
  endtask : send
  // samples mid-bit and returns at mid stop, in time for a back-to-back start
  task automatic recv(input int n, output logic [8:0] w);
    w = 9'h000;
    @(negedge i_tx);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CLKS) @(posedge i_clk);
      w[i] = i_tx;
    end
    repeat (BIT_CLKS) @(posedge i_clk);
  endtask : recv
endmodule : uti_remote

// *** bench/uti_datapath_tb.sv ***
// self-checking bench for the serial datapath
`timescale 1ns/1ps
module uti_datapath_tb;
  import uti_pkg::*;
  localparam int CYC_LIMIT = 30000;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, rx, tx, tx_irq, rx_irq;
  logic [1:0] bresp, rresp;
  logic [8:0] w;
  int fails = 0, num_checks = 0, irqs = 0, cycles = 0;
  time t0;
  uti_datapath u_dut (.I_MCLK(clk), .I_NRST(nrst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_RX(rx), .O_TX(tx), .O_TX_IRQ(tx_irq),
    .O_RX_IRQ(rx_irq));
  uti_remote u_rem (.i_clk(clk), .i_tx(tx), .o_rx(rx));
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] resp = RESP_OKAY);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, resp});
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] resp = RESP_OKAY);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, resp});
  endtask : rd
  initial forever #20 clk = ~clk;
  // the limit also ends a wait on a line that never moves
  always @(posedge clk) begin
    if (rx_irq === 1'h1) irqs++;
    cycles++;
    if (cycles == CYC_LIMIT) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    rd(OFF_STATUS, 32'h0000_00d0);
    rd(32'h0000_0010, 32'h0000_0000, RESP_SLVERR);
    wr(32'h0000_0010, 32'h0000_00ff, RESP_SLVERR);
    // divisor zero: sixteen clocks a bit keeps the run short
    wr(OFF_CTRL2, 32'h0000_0003);
    wr(OFF_CTRL1, 32'h0000_0060);
    fork
      begin
        rd(OFF_STATUS, 32'h0000_00d0);
        wr(OFF_DATA, 32'h0000_00a5);
        rd(OFF_STATUS, 32'h0000_0090);
        wr(OFF_DATA, 32'h0000_003c);
        rd(OFF_STATUS, 32'h0000_0010);
        wr(OFF_DATA, 32'h0000_0055);
      end
      begin
        u_rem.recv(8, w);
        chk({23'h0, w}, 32'h0000_00a5);
        u_rem.recv(8, w);
        chk({23'h0, w}, 32'h0000_003c);
      end
    join
    chk({31'h0, tx_irq}, 32'h1);
    repeat (40) @(posedge clk);
    rd(OFF_STATUS, 32'h0000_00d0);
    wr(OFF_CTRL2, 32'h0000_0002);
    // the request follows the enable one cycle late; look once it has settled
    @(negedge clk);
    chk({31'h0, tx_irq}, 32'h0);
    wr(OFF_CTRL1, 32'h0000_0069);
    fork
      begin
        rd(OFF_STATUS, 32'h0000_00d0);
        wr(OFF_DATA, 32'h0000_0012);
      end
      u_rem.recv(9, w);
    join
    chk({23'h0, w}, 32'h0000_0112);
    $display("transmit test done");
    u_rem.send(9'h1c3, 9, 1'h1);
    rd(OFF_CTRL1, 32'h0000_006b);
    rd(OFF_STATUS, 32'h0000_00f0);
    rd(OFF_DATA, 32'h0000_00c3);
    rd(OFF_STATUS, 32'h0000_00d0);
    chk(irqs, 32'h1);
    wr(OFF_CTRL1, 32'h0000_0060);
    u_rem.send(9'h011, 8, 1'h1);
    u_rem.send(9'h022, 8, 1'h1);
    u_rem.send(9'h033, 8, 1'h1);
    rd(OFF_STATUS, 32'h0000_00f8);
    rd(OFF_DATA, 32'h0000_0011);
    rd(OFF_STATUS, 32'h0000_00f0);
    rd(OFF_DATA, 32'h0000_0022);
    rd(OFF_STATUS, 32'h0000_00d0);
    chk(irqs, 32'h4);
    $display("receive test done");
    u_rem.send(9'h000, 8, 1'h0);
    repeat (200) @(posedge clk);
    rd(OFF_STATUS, 32'h0000_00f4);
    rd(OFF_DATA, 32'h0000_0000);
    rd(OFF_STATUS, 32'h0000_00d0);
    chk(irqs, 32'h5);
    wr(OFF_CTRL1, 32'h0000_0070);
    @(negedge tx);
    t0 = $time;
    // cleared in the second break, so two breaks must go out before the stop
    repeat (300) @(posedge clk);
    wr(OFF_CTRL1, 32'h0000_0060);
    @(posedge tx);
    chk({31'h0, ($time - t0) >= 64'h4380}, 32'h1);
    repeat (40) @(posedge clk);
    rd(OFF_STATUS, 32'h0000_00d0);
    $display("break test done");
    rd(OFF_STATUS, 32'h0000_00d0);
    wr(OFF_DATA, 32'h0000_0000);
    // all-zero word keeps the line low, so only the abort can raise it
    repeat (20) @(posedge clk);
    chk({31'h0, tx}, 32'h0);
    wr(OFF_CTRL1, 32'h0000_0020);
    @(negedge clk);
    chk({31'h0, tx}, 32'h1);
    rd(OFF_STATUS, 32'h0000_00d0);
    $display("disable test done");
    finish_test();
  end
endmodule : uti_datapath_tb
